// [pkg/tpm_pkg.sv]
// Constants and types shared by the test pin mode and probe control ends
// Overview of operation
// - Flexible mode: mode-select low claims test pins
// - Test pins stay claimed until logic-reset
// - Logic-reset returns test pins to user I/O
// - Five clocks, mode-select high, reach logic-reset
// - Dedicated mode: standard mode-select, no sharing
// - First probe pin shows selected node
// - Both probe pins show two nodes together
// - Probe pins may serve as user I/O
// - Permanent probe disable hides every node
// - Serial data input feeds scan and selection
// - Serial data output shifts scan results
// - Test clock times scan work and probe selection; the core clock times the probe pins
// - Pins act as input, output, tristate; none is bidirectional
package tpm_pkg;
   localparam int NODE_CNT   = 16;
   localparam int SEL_W      = 4;
   localparam int PROBE_CNT  = 2;
   localparam int SEL_DR_W   = PROBE_CNT * (SEL_W + 1);
   localparam int SCAN_DR_W  = SEL_DR_W + 1;
   localparam int DR_IDX_W   = 4;
   localparam int IR_W       = 2;
   localparam logic [1:0] IR_LOCK    = 2'h0;
   localparam logic [1:0] IR_SCAN    = 2'h1;
   localparam logic [1:0] IR_PSEL    = 2'h2;
   localparam logic [1:0] IR_BYPASS  = 2'h3;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam logic [SEL_DR_W-1:0] SEL_RESET = 10'h000;
   localparam int RESET_TMS_CNT = 5;
   localparam int TCK_HALF_CYC  = 4;
   localparam int PH_W          = 2;
   localparam int DATA_W        = 16;
   localparam int LEN_W         = 5;
   localparam int SEQ_W         = 24;
   localparam int PRE_IR        = 5;
   localparam int PRE_DR        = 4;
   localparam logic [4:0] PAT_IR = 5'h06;
   localparam logic [4:0] PAT_DR = 5'h02;
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } tpm_tap_t;
   typedef enum logic [1:0] {OP_RESET, OP_IR, OP_DR} tpm_op_t;
endpackage : tpm_pkg

// [pkg/tpm_if.sv]
// Link between the tester end and the device end
`timescale 1ns/10ps
`default_nettype none
interface tpm_if;
   logic       tck;
   logic       tms;
   logic       tdi;
   logic       tdo_out;
   logic       tdo_oe;
   logic       tdo;
   logic [1:0] probe_out;
   logic [1:0] probe_oe;
   logic [1:0] probe_lvl;
   // Undriven data output floats high through a pull-up
   assign tdo       = tdo_oe ? tdo_out : 1'b1;
   // Undriven probe pins are pulled low
   assign probe_lvl = probe_out & probe_oe;
   modport dev (input tck, input tms, input tdi,
                output tdo_out, output tdo_oe,
                output probe_out, output probe_oe);
   modport tst (output tck, output tms, output tdi,
                input tdo, input probe_lvl);
endinterface : tpm_if
`default_nettype wire

// [rtl/tpm_tap_fsm.sv]
// Boundary-scan controller state machine on the test clock
`timescale 1ns/10ps
`default_nettype none
module tpm_tap_fsm (
   input  wire logic         tck_i,
   input  wire logic         rst_b_i,
   input  wire logic         tms_i,
   output var tpm_pkg::tpm_tap_t state_o
);
   tpm_pkg::tpm_tap_t nxt_state;

   // Any state reaches logic-reset after five high mode-select clocks
   always_comb begin
      unique case (state_o)
         tpm_pkg::TAP_RESET:  nxt_state = tms_i ? tpm_pkg::TAP_RESET  : tpm_pkg::TAP_IDLE;
         tpm_pkg::TAP_IDLE:   nxt_state = tms_i ? tpm_pkg::TAP_SEL_DR : tpm_pkg::TAP_IDLE;
         tpm_pkg::TAP_SEL_DR: nxt_state = tms_i ? tpm_pkg::TAP_SEL_IR : tpm_pkg::TAP_CAP_DR;
         tpm_pkg::TAP_CAP_DR: nxt_state = tms_i ? tpm_pkg::TAP_EX1_DR : tpm_pkg::TAP_SH_DR;
         tpm_pkg::TAP_SH_DR:  nxt_state = tms_i ? tpm_pkg::TAP_EX1_DR : tpm_pkg::TAP_SH_DR;
         tpm_pkg::TAP_EX1_DR: nxt_state = tms_i ? tpm_pkg::TAP_UPD_DR : tpm_pkg::TAP_PAU_DR;
         tpm_pkg::TAP_PAU_DR: nxt_state = tms_i ? tpm_pkg::TAP_EX2_DR : tpm_pkg::TAP_PAU_DR;
         tpm_pkg::TAP_EX2_DR: nxt_state = tms_i ? tpm_pkg::TAP_UPD_DR : tpm_pkg::TAP_SH_DR;
         tpm_pkg::TAP_UPD_DR: nxt_state = tms_i ? tpm_pkg::TAP_SEL_DR : tpm_pkg::TAP_IDLE;
         tpm_pkg::TAP_SEL_IR: nxt_state = tms_i ? tpm_pkg::TAP_RESET  : tpm_pkg::TAP_CAP_IR;
         tpm_pkg::TAP_CAP_IR: nxt_state = tms_i ? tpm_pkg::TAP_EX1_IR : tpm_pkg::TAP_SH_IR;
         tpm_pkg::TAP_SH_IR:  nxt_state = tms_i ? tpm_pkg::TAP_EX1_IR : tpm_pkg::TAP_SH_IR;
         tpm_pkg::TAP_EX1_IR: nxt_state = tms_i ? tpm_pkg::TAP_UPD_IR : tpm_pkg::TAP_PAU_IR;
         tpm_pkg::TAP_PAU_IR: nxt_state = tms_i ? tpm_pkg::TAP_EX2_IR : tpm_pkg::TAP_PAU_IR;
         tpm_pkg::TAP_EX2_IR: nxt_state = tms_i ? tpm_pkg::TAP_UPD_IR : tpm_pkg::TAP_SH_IR;
         tpm_pkg::TAP_UPD_IR: nxt_state = tms_i ? tpm_pkg::TAP_SEL_DR : tpm_pkg::TAP_IDLE;
      endcase
   end

   // State register, starts in logic-reset
   always_ff @(posedge tck_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_o <= tpm_pkg::TAP_RESET;
      end else begin
         state_o <= nxt_state;
      end
   end
endmodule : tpm_tap_fsm
`default_nettype wire

// [rtl/tpm_device.sv]
// Device end: shared test pins, scan chain and probe pin control
`timescale 1ns/10ps
`default_nettype none
module tpm_device (
   input  wire logic                          clock_i,
   input  wire logic                          rst_b_i,
   input  wire logic                          dedicated_mode_i,
   input  wire logic [tpm_pkg::NODE_CNT-1:0]  node_i,
   input  wire logic                          usr_tdo_i,
   input  wire logic                          usr_tdo_oe_i,
   input  wire logic [tpm_pkg::PROBE_CNT-1:0] usr_probe_i,
   input  wire logic [tpm_pkg::PROBE_CNT-1:0] usr_probe_oe_i,
   tpm_if.dev                                 link,
   output logic                               test_mode_o,
   output logic                               usr_tdi_o,
   output logic                               probe_lock_o
);
   localparam int SW = tpm_pkg::SEL_W + 1;

   // Test clock domain
   logic                                ded_s1_ff;
   logic                                ded_s2_ff;
   tpm_pkg::tpm_tap_t                   tap_state;
   logic                                tm_ff;
   logic [tpm_pkg::IR_W-1:0]            ir_sr_ff;
   logic [tpm_pkg::IR_W-1:0]            ir_ff;
   logic [tpm_pkg::SCAN_DR_W-1:0]       dr_sr_ff;
   logic [tpm_pkg::SCAN_DR_W-1:0]       nxt_dr_sr;
   logic [tpm_pkg::DR_IDX_W-1:0]        dr_msb;
   logic [tpm_pkg::SEL_DR_W-1:0]        sel_ff;
   logic                                lock_ff;
   logic                                upd_tgl_ff;
   logic                                tdo_ff;
   logic                                tdo_oe_ff;
   // Core clock domain
   logic                                tm_s1_ff;
   logic                                tdi_s1_ff;
   logic                                tgl_s1_ff;
   logic                                tgl_s2_ff;
   logic                                tgl_s3_ff;
   logic                                lock_s1_ff;
   logic [tpm_pkg::SEL_DR_W-1:0]        csel_ff;
   logic                                usr_tdo_ff;
   logic                                usr_oe_ff;
   logic [tpm_pkg::PROBE_CNT-1:0]       probe_out_ff;
   logic [tpm_pkg::PROBE_CNT-1:0]       probe_oe_ff;

   tpm_tap_fsm u_tap (
      .tck_i   (link.tck),
      .rst_b_i (rst_b_i),
      .tms_i   (link.tms),
      .state_o (tap_state)
   );

   // Strap is static, so two test-clock flops are enough even with a
   // test clock that only runs during frames
   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ded_s1_ff <= 1'b0;
         ded_s2_ff <= 1'b0;
      end else begin
         ded_s1_ff <= dedicated_mode_i;
         ded_s2_ff <= ded_s1_ff;
      end
   end

   // Pin ownership: a low mode-select claims the pins, and the claim
   // wins over a release in the same edge. The release lands on the
   // edge that enters logic-reset, not one edge later, so five high
   // rises from any state are enough
   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tm_ff <= 1'b0;
      end else if (ded_s2_ff) begin
         tm_ff <= 1'b1;
      end else if (!link.tms) begin
         tm_ff <= 1'b1;
      end else if (tap_state == tpm_pkg::TAP_RESET ||
                   tap_state == tpm_pkg::TAP_SEL_IR) begin
         tm_ff <= 1'b0;
      end
   end

   // Instruction register
   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ir_sr_ff <= tpm_pkg::IR_CAPTURE;
         ir_ff    <= tpm_pkg::IR_BYPASS;
      end else begin
         unique case (tap_state)
            tpm_pkg::TAP_RESET:  ir_ff    <= tpm_pkg::IR_BYPASS;
            tpm_pkg::TAP_CAP_IR: ir_sr_ff <= tpm_pkg::IR_CAPTURE;
            tpm_pkg::TAP_SH_IR:  ir_sr_ff <= {link.tdi, ir_sr_ff[1]};
            tpm_pkg::TAP_UPD_IR: ir_ff    <= ir_sr_ff;
            default:             ir_sr_ff <= ir_sr_ff;
         endcase
      end
   end

   // Top bit of the selected data register; serial data enters there
   always_comb begin
      unique case (ir_ff)
         tpm_pkg::IR_SCAN: dr_msb = 4'(tpm_pkg::SCAN_DR_W - 1);
         tpm_pkg::IR_PSEL: dr_msb = 4'(tpm_pkg::SEL_DR_W - 1);
         tpm_pkg::IR_LOCK,
         tpm_pkg::IR_BYPASS: dr_msb = 4'h0;
      endcase
   end

   // Data register capture and shift
   always_comb begin
      nxt_dr_sr = dr_sr_ff;
      if (tap_state == tpm_pkg::TAP_CAP_DR) begin
         unique case (ir_ff)
            tpm_pkg::IR_SCAN: nxt_dr_sr = {lock_ff, sel_ff};
            tpm_pkg::IR_PSEL: nxt_dr_sr = {1'b0, sel_ff};
            tpm_pkg::IR_LOCK,
            tpm_pkg::IR_BYPASS: nxt_dr_sr = '0;
         endcase
      end else if (tap_state == tpm_pkg::TAP_SH_DR) begin
         nxt_dr_sr         = dr_sr_ff >> 1;
         nxt_dr_sr[dr_msb] = link.tdi;
      end
   end

   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dr_sr_ff <= '0;
      end else begin
         dr_sr_ff <= nxt_dr_sr;
      end
   end

   // Probe selection is refused once the probes are locked
   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_ff     <= tpm_pkg::SEL_RESET;
         upd_tgl_ff <= 1'b0;
      end else if (tap_state == tpm_pkg::TAP_UPD_DR &&
                   ir_ff == tpm_pkg::IR_PSEL && !lock_ff) begin
         sel_ff     <= dr_sr_ff[tpm_pkg::SEL_DR_W-1:0];
         upd_tgl_ff <= ~upd_tgl_ff;
      end
   end

   // Lock is never cleared short of a power-on reset
   always_ff @(posedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_ff <= 1'b0;
      end else if (tap_state == tpm_pkg::TAP_UPD_DR &&
                   ir_ff == tpm_pkg::IR_LOCK) begin
         lock_ff <= 1'b1;
      end
   end

   // Serial output changes on the falling test clock edge
   always_ff @(negedge link.tck or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_ff    <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_ff    <= (tap_state == tpm_pkg::TAP_SH_IR) ? ir_sr_ff[0]
                                                        : dr_sr_ff[0];
         tdo_oe_ff <= (tap_state == tpm_pkg::TAP_SH_IR) ||
                      (tap_state == tpm_pkg::TAP_SH_DR);
      end
   end

   // Shared output pin: scan owns it in test mode, user logic otherwise
   assign link.tdo_out = tm_ff ? tdo_ff : usr_tdo_ff;
   assign link.tdo_oe  = tm_ff ? tdo_oe_ff : usr_oe_ff;

   // User drive of the shared output pin
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         usr_tdo_ff <= 1'b0;
         usr_oe_ff  <= 1'b0;
      end else begin
         usr_tdo_ff <= usr_tdo_i;
         usr_oe_ff  <= usr_tdo_oe_i;
      end
   end

   // Levels into the core clock domain
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tm_s1_ff     <= 1'b0;
         test_mode_o  <= 1'b0;
         tdi_s1_ff    <= 1'b0;
         usr_tdi_o    <= 1'b0;
         lock_s1_ff   <= 1'b0;
         probe_lock_o <= 1'b0;
      end else begin
         tm_s1_ff     <= tm_ff;
         test_mode_o  <= tm_s1_ff;
         tdi_s1_ff    <= link.tdi;
         usr_tdi_o    <= tdi_s1_ff;
         lock_s1_ff   <= lock_ff;
         probe_lock_o <= lock_s1_ff;
      end
   end

   // Selection word crosses by toggle; the word is held steady while
   // the toggle travels, so no bit can be caught half updated
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgl_s1_ff <= 1'b0;
         tgl_s2_ff <= 1'b0;
         tgl_s3_ff <= 1'b0;
         csel_ff   <= tpm_pkg::SEL_RESET;
      end else begin
         tgl_s1_ff <= upd_tgl_ff;
         tgl_s2_ff <= tgl_s1_ff;
         tgl_s3_ff <= tgl_s2_ff;
         if (tgl_s2_ff != tgl_s3_ff) begin
            csel_ff <= sel_ff;
         end
      end
   end

   // Each probe pin: a selected node, or plain user I/O when disabled
   for (genvar gi = 0; gi < tpm_pkg::PROBE_CNT; gi++) begin : g_probe
      logic                     en;
      logic [tpm_pkg::SEL_W-1:0] idx;
      assign idx = csel_ff[gi*SW +: tpm_pkg::SEL_W];
      assign en  = csel_ff[gi*SW + tpm_pkg::SEL_W] & ~probe_lock_o;
      always_ff @(posedge clock_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            probe_out_ff[gi] <= 1'b0;
            probe_oe_ff[gi]  <= 1'b0;
         end else if (en) begin
            probe_out_ff[gi] <= node_i[idx];
            probe_oe_ff[gi]  <= 1'b1;
         end else begin
            probe_out_ff[gi] <= usr_probe_i[gi];
            probe_oe_ff[gi]  <= usr_probe_oe_i[gi];
         end
      end
   end

   assign link.probe_out = probe_out_ff;
   assign link.probe_oe  = probe_oe_ff;
endmodule : tpm_device
`default_nettype wire

// [rtl/tpm_tester.sv]
// Tester end: makes the test clock and runs scan frames
`timescale 1ns/10ps
`default_nettype none
module tpm_tester (
   input  wire logic                          clock_i,
   input  wire logic                          rst_b_i,
   input  wire logic                          cmd_valid_i,
   input  wire tpm_pkg::tpm_op_t              cmd_op_i,
   input  wire logic [tpm_pkg::LEN_W-1:0]     cmd_len_i,
   input  wire logic [tpm_pkg::DATA_W-1:0]    cmd_data_i,
   tpm_if.tst                                 link,
   output logic                               cmd_ready_o,
   output logic                               rsp_valid_o,
   output logic [tpm_pkg::DATA_W-1:0]         rsp_data_o,
   output logic [tpm_pkg::PROBE_CNT-1:0]      probe_o
);
   localparam int SW = tpm_pkg::SEQ_W;

   logic                             busy_ff;
   logic                             tck_ff;
   logic                             tms_ff;
   logic                             tdi_ff;
   logic [tpm_pkg::PH_W-1:0]         ph_ff;
   logic [SW-1:0]                    tms_seq_ff;
   logic [SW-1:0]                    tdi_seq_ff;
   logic [SW-1:0]                    nxt_tms_seq;
   logic [SW-1:0]                    nxt_tdi_seq;
   logic [tpm_pkg::LEN_W-1:0]        idx_ff;
   logic [tpm_pkg::LEN_W-1:0]        last_ff;
   logic [tpm_pkg::LEN_W-1:0]        pre_ff;
   logic [tpm_pkg::LEN_W-1:0]        end_ff;
   logic [tpm_pkg::LEN_W-1:0]        nxt_last;
   logic [tpm_pkg::LEN_W-1:0]        nxt_pre;
   logic [tpm_pkg::LEN_W-1:0]        len;
   logic                             tdo_s1_ff;
   logic                             tdo_s2_ff;
   logic [tpm_pkg::PROBE_CNT-1:0]    prb_s1_ff;
   logic                             edge_now;

   // Zero-length scans are run as one bit
   assign len      = (cmd_len_i == '0) ? 5'h01 : cmd_len_i;
   assign edge_now = (ph_ff == tpm_pkg::PH_W'(tpm_pkg::TCK_HALF_CYC - 1));

   // Frame pattern: walk to the shift state, shift, update, idle
   always_comb begin
      nxt_tms_seq = '0;
      nxt_tdi_seq = '0;
      nxt_pre     = (cmd_op_i == tpm_pkg::OP_IR) ? 5'(tpm_pkg::PRE_IR)
                                                 : 5'(tpm_pkg::PRE_DR);
      nxt_last    = 5'(nxt_pre + len + 5'h01);
      if (cmd_op_i == tpm_pkg::OP_RESET) begin
         nxt_pre     = 5'(tpm_pkg::RESET_TMS_CNT);
         nxt_last    = 5'(tpm_pkg::RESET_TMS_CNT - 1);
         nxt_tms_seq = SW'((1 << tpm_pkg::RESET_TMS_CNT) - 1);
      end else begin
         nxt_tms_seq = (cmd_op_i == tpm_pkg::OP_IR) ? SW'(tpm_pkg::PAT_IR)
                                                    : SW'(tpm_pkg::PAT_DR);
         nxt_tms_seq[5'(nxt_pre + len - 5'h01)] = 1'b1;
         nxt_tms_seq[5'(nxt_pre + len)]         = 1'b1;
         nxt_tdi_seq = SW'(cmd_data_i) << nxt_pre;
      end
   end

   // Test clock divider and frame walk
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_ff    <= 1'b0;
         tck_ff     <= 1'b0;
         tms_ff     <= 1'b1;
         tdi_ff     <= 1'b0;
         ph_ff      <= '0;
         idx_ff     <= '0;
         last_ff    <= '0;
         pre_ff     <= '0;
         end_ff     <= '0;
         tms_seq_ff <= '0;
         tdi_seq_ff <= '0;
      end else if (!busy_ff) begin
         ph_ff <= '0;
         if (cmd_valid_i) begin
            busy_ff    <= 1'b1;
            idx_ff     <= '0;
            last_ff    <= nxt_last;
            pre_ff     <= nxt_pre;
            end_ff     <= 5'(nxt_pre + len);
            tms_seq_ff <= nxt_tms_seq >> 1;
            tdi_seq_ff <= nxt_tdi_seq >> 1;
            tms_ff     <= nxt_tms_seq[0];
            tdi_ff     <= nxt_tdi_seq[0];
         end
      end else begin
         ph_ff <= edge_now ? '0 : ph_ff + 1'b1;
         if (edge_now && !tck_ff) begin
            tck_ff <= 1'b1;
         end else if (edge_now) begin
            tck_ff <= 1'b0;
            if (idx_ff == last_ff) begin
               busy_ff <= 1'b0; // Mode-select keeps its last level
            end else begin
               idx_ff     <= idx_ff + 1'b1;
               tms_ff     <= tms_seq_ff[0];
               tdi_ff     <= tdi_seq_ff[0];
               tms_seq_ff <= tms_seq_ff >> 1;
               tdi_seq_ff <= tdi_seq_ff >> 1;
            end
         end
      end
   end

   // Ready and done flags
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
      end else begin
         rsp_valid_o <= busy_ff && edge_now && tck_ff && idx_ff == last_ff;
         cmd_ready_o <= !busy_ff && !cmd_valid_i ||
                        busy_ff && edge_now && tck_ff && idx_ff == last_ff;
      end
   end

   // Pin inputs pass two flops first
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_s1_ff <= 1'b1;
         tdo_s2_ff <= 1'b1;
         prb_s1_ff <= '0;
         probe_o   <= '0;
      end else begin
         tdo_s1_ff <= link.tdo;
         tdo_s2_ff <= tdo_s1_ff;
         prb_s1_ff <= link.probe_lvl;
         probe_o   <= prb_s1_ff;
      end
   end

   // Sample serial output at each rising edge inside the shift window
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rsp_data_o <= '0;
      end else if (busy_ff && !busy_ff == 1'b0 && idx_ff == '0 &&
                   ph_ff == '0 && !tck_ff) begin
         rsp_data_o <= '0;
      end else if (busy_ff && edge_now && !tck_ff &&
                   idx_ff >= pre_ff && idx_ff < end_ff) begin
         rsp_data_o[4'(idx_ff - pre_ff)] <= tdo_s2_ff;
      end
   end

   assign link.tck = tck_ff;
   assign link.tms = tms_ff;
   assign link.tdi = tdi_ff;
endmodule : tpm_tester
`default_nettype wire

// [testbench/tpm_monitor.sv]
// Checker of the link between the tester end and the device end
`timescale 1ns/10ps
`default_nettype none
module tpm_monitor (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_out,
   input wire logic tdo_oe,
   input wire logic tdo
);
   // Pin levels and test clock shape, seen from the core clock
   AST_PULLUP: assert property (
      @(posedge clock_i) disable iff (!rst_b_i) !tdo_oe |-> tdo)
      else $error("Released data-out pin not high");
   AST_OE_RISE: assert property (
      @(posedge clock_i) disable iff (!rst_b_i) $rose(tdo_oe) |-> !tck)
      else $error("Data output enabled with clock high");
   AST_TCK_HIGH: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      $rose(tck) |-> tck [*4] ##1 !tck)
      else $error("Test clock high phase wrong");
   AST_TCK_LOW: assert property (
      @(posedge clock_i) disable iff (!rst_b_i) $fell(tck) |-> !tck [*4])
      else $error("Test clock low phase too short");
   // Mode and data lines move only while the test clock is low
   AST_TMS_EDGE: assert property (
      @(posedge clock_i) disable iff (!rst_b_i) !$stable(tms) |-> !tck)
      else $error("Mode select moved with clock high");
   AST_TDI_EDGE: assert property (
      @(posedge clock_i) disable iff (!rst_b_i) !$stable(tdi) |-> !tck)
      else $error("Data input moved with clock high");
   AST_SETUP: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      $rose(tck) |-> $stable(tms) && $stable(tdi))
      else $error("Inputs not settled before clock rise");
   AST_TDO_FALL: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      tdo_oe && $past(tdo_oe) && !$stable(tdo_out) |-> !tck)
      else $error("Data output moved with clock high");
   // Five rises with mode select high leave the data output undriven at the next rise, dedicated strap or not
   AST_RELEASE: assert property (
      @(posedge tck) disable iff (!rst_b_i) tms [*5] |=> !tdo_oe)
      else $error("Pins still driven after five high rises");
endmodule : tpm_monitor
`default_nettype wire

// [testbench/test_pin_mode_and_probe_control_bench.sv]
// Bench joining tester and device ends with a reference model
`timescale 1ns/10ps
`default_nettype none
module test_pin_mode_and_probe_control_bench;
   logic              clock_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic              vld     = 1'b0;
   logic              ded     = 1'b0;
   tpm_pkg::tpm_op_t  op      = tpm_pkg::OP_RESET;
   logic [4:0]        len     = 5'h00;
   logic [15:0]       dat     = 16'h0000;
   logic [15:0]       node    = 16'h0000;
   logic              utdo    = 1'b0;
   logic              utdo_oe = 1'b0;
   logic [1:0]        upr     = 2'h0;
   logic [1:0]        upr_oe  = 2'h0;
   logic              rdy, rv, tmode, utdi, lock;
   logic [15:0]       rd, d;
   logic [1:0]        pr;
   logic [9:0]        s;
   int                err_total = 0;
   int                tests_run = 0;
   int                seed = 25;
   tpm_if link ();
   // Core clock, 100 ns period
   always #50 clock_i = ~clock_i;
   tpm_device tpm_device_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .dedicated_mode_i(ded), .node_i(node), .usr_tdo_i(utdo),
      .usr_tdo_oe_i(utdo_oe), .usr_probe_i(upr), .usr_probe_oe_i(upr_oe),
      .link(link), .test_mode_o(tmode), .usr_tdi_o(utdi),
      .probe_lock_o(lock));
   tpm_tester tpm_tester_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .cmd_valid_i(vld), .cmd_op_i(op), .cmd_len_i(len),
      .cmd_data_i(dat), .link(link), .cmd_ready_o(rdy),
      .rsp_valid_o(rv), .rsp_data_o(rd), .probe_o(pr));
   tpm_monitor tpm_monitor_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
      .tdo_out(link.tdo_out), .tdo_oe(link.tdo_oe), .tdo(link.tdo));
   task automatic close_out();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic chk(string nm, logic [15:0] e, logic [15:0] v);
      tests_run++;
      if (v !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, v);
      end
   endtask : chk
   // One frame: wait for ready, one-cycle request, bounded wait for done
   task automatic run(tpm_pkg::tpm_op_t o, int n, logic [15:0] x);
      int k;
      k = 0;
      while (rdy !== 1'b1 && k < 100) begin
         @(negedge clock_i);
         k++;
      end
      if (k >= 100) begin
         err_total++;
         close_out();
      end
      op  = o;
      len = 5'(n);
      dat = x;
      vld = 1'b1;
      @(negedge clock_i);
      vld = 1'b0;
      while (rv !== 1'b1 && k < 500) begin
         @(negedge clock_i);
         k++;
      end
      if (k >= 500) begin
         err_total++;
         close_out();
      end
   endtask : run
   // Model: enabled unlocked probe shows its node, else the user drive
   task automatic probe_chk(logic [9:0] sel, logic lk);
      logic [1:0] e;
      repeat (12) @(negedge clock_i);
      for (int p = 0; p < 2; p++) begin
         e[p] = (sel[p*5+4] && !lk) ? node[sel[p*5 +: 4]]
                                    : upr[p] & upr_oe[p];
      end
      chk("probe", {14'h0, e}, {14'h0, pr});
   endtask : probe_chk
   initial begin
      node   = 16'($random(seed));
      upr    = 2'($random(seed));
      upr_oe = 2'($random(seed));
      repeat (10) @(negedge clock_i);
      rst_b_i = 1'b1;
      chk("idle tdo", 16'h1, {15'h0, link.tdo});
      chk("mode", 16'h0, {15'h0, tmode});
      run(tpm_pkg::OP_IR, 2, 16'(tpm_pkg::IR_BYPASS));
      chk("ir cap", 16'(tpm_pkg::IR_CAPTURE), {14'h0, rd[1:0]});
      chk("claim", 16'h1, {15'h0, tmode});
      d = 16'($random(seed));
      run(tpm_pkg::OP_DR, 16, d);
      chk("bypass", {d[14:0], 1'b0}, rd);
      // Both probes together first, then random selections
      for (int i = 0; i < 4; i++) begin
         s = (i == 0) ? 10'h279 : 10'($random(seed));
         run(tpm_pkg::OP_IR, 2, 16'(tpm_pkg::IR_PSEL));
         run(tpm_pkg::OP_DR, 10, {6'h00, s});
         probe_chk(s, 1'b0);
         node = ~node;
         probe_chk(s, 1'b0);
      end
      chk("held", 16'h1, {15'h0, tmode});
      // Lock, then a new selection must stay hidden
      run(tpm_pkg::OP_IR, 2, 16'(tpm_pkg::IR_LOCK));
      run(tpm_pkg::OP_DR, 1, 16'h0001);
      run(tpm_pkg::OP_IR, 2, 16'(tpm_pkg::IR_PSEL));
      run(tpm_pkg::OP_DR, 10, 16'h0279);
      probe_chk(10'h279, 1'b1);
      chk("lock", 16'h1, {15'h0, lock});
      // Scan register shows the lock bit over the last kept selection
      run(tpm_pkg::OP_IR, 2, 16'(tpm_pkg::IR_SCAN));
      run(tpm_pkg::OP_DR, 11, 16'h0000);
      chk("scan", {5'h00, 1'b1, s}, rd);
      run(tpm_pkg::OP_RESET, 5, 16'h0000);
      repeat (4) @(negedge clock_i);
      chk("release", 16'h0, {15'h0, tmode});
      chk("user tdi", {15'h0, link.tdi}, {15'h0, utdi});
      // Dedicated strap claims the released pins during a reset walk and keeps them
      ded = 1'b1;
      run(tpm_pkg::OP_RESET, 5, 16'h0000);
      repeat (4) @(negedge clock_i);
      chk("dedicated", 16'h1, {15'h0, tmode});
      ded = 1'b0;
      run(tpm_pkg::OP_RESET, 5, 16'h0000);
      repeat (4) @(negedge clock_i);
      chk("undedicated", 16'h0, {15'h0, tmode});
      utdo    = 1'($random(seed));
      utdo_oe = 1'b1;
      repeat (3) @(negedge clock_i);
      chk("user tdo", {15'h0, utdo}, {15'h0, link.tdo});
      utdo_oe = 1'b0;
      repeat (3) @(negedge clock_i);
      close_out();
   end
endmodule : test_pin_mode_and_probe_control_bench
`default_nettype wire
